// [sim/sac_host_model.sv]
// Host-side model driving the start and serial clock pins
`timescale 1ns/1ps
module sac_host_model (
  // Clock
  input wire logic clk_i,
  // Pins to the device
  output logic convert_start_o,
  output logic sck_o,
  output logic sdo_en_o,
  // Serial data from the device
  input wire logic sdo_i
);
  initial begin
    convert_start_o = 1'b0;
    sck_o = 1'b0;
    sdo_en_o = 1'b1;
  end
  // Short pulse: the fall lands well inside the 40 ns guard
  task automatic pulse();
    @(posedge clk_i) convert_start_o <= 1'b1;
    repeat (2) @(posedge clk_i);
    convert_start_o <= 1'b0;
    repeat (2) @(posedge clk_i);
  endtask : pulse
  // One 80 ns serial clock period; data taken late in the low half
  task automatic sck_bit(output logic b);
    @(posedge clk_i) sck_o <= 1'b1;
    repeat (10) @(posedge clk_i);
    sck_o <= 1'b0;
    repeat (9) @(posedge clk_i);
    b = sdo_i;
  endtask : sck_bit
endmodule : sac_host_model

// [sim/testbench.sv]
// Self-checking bench for the conversion controller and its FIFO
`timescale 1ns/1ps
`define CHK(nm, e, g) begin cmp_count++; if ((g) !== (e)) begin \
  miscompares++; $display("CHECK FAILED %s exp %0h got %0h", nm, e, g); \
  end end
module testbench;
  logic clk_i = 1'b0;
  logic rstn_i = 1'b0;
  logic cs, sck, sen, busy, sdo, oe, core, refp, rdy, rok;
  logic [17:0] smp = 18'h00000;
  int miscompares = 0;
  int cmp_count = 0;
  always #2 clk_i = ~clk_i;
  sac_host_model host (.clk_i(clk_i), .convert_start_o(cs), .sck_o(sck),
    .sdo_en_o(sen), .sdo_i(sdo));
  sac_conv_ctrl #(.POR_CYC(50), .WAKE_CYC(20), .DEPTH(4)) dut (
    .clk_i(clk_i), .rstn_i(rstn_i), .convert_start_i(cs), .sck_i(sck),
    .sdo_en_i(sen), .sample_i(smp), .busy_o(busy), .sdo_o(sdo),
    .sdo_oe_o(oe), .core_pwr_o(core), .ref_pwr_o(refp), .ready_o(rdy),
    .result_ok_o(rok));

  task automatic print_verdict();
    $display("Compares %0d, mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : print_verdict

  // Converts w; a second pulse inside the guard asks for sleep
  task automatic conv(input bit dbl, input logic [17:0] w);
    int nb = 0;
    int nc = 0;
    @(posedge clk_i) smp <= w;
    fork
      begin
        host.pulse();
        if (dbl) host.pulse();
      end
    join_none
    for (int t = 0; t < 400 && !(nb > 0 && busy === 1'b0); t++) begin
      @(posedge clk_i);
      #1;
      nb += (busy === 1'b1);
      nc += (core === 1'b1);
    end
    `CHK("core_cycles", sac_pkg::CONV_CYC, nc)
    `CHK("busy_cycles", sac_pkg::CONV_CYC + 1, nb)
    `CHK("msb_at_busy_fall", w[17], sdo)
    `CHK("core_off", 1'b0, core)
  endtask : conv

  // Start edge that must not begin a conversion
  task automatic refused();
    fork
      host.pulse();
    join_none
    repeat (30) begin
      @(posedge clk_i);
      #1;
      `CHK("busy_refused", 1'b0, busy)
    end
  endtask : refused

  // Reads the rest of the word; poke tries an early start mid-word
  task automatic read_word(input logic [17:0] w, input bit poke);
    logic [17:0] got;
    logic b;
    got[17] = sdo;
    for (int i = 16; i >= 0; i--) begin
      host.sck_bit(b);
      got[i] = b;
      if (poke && i == 16) refused();
    end
    `CHK("word", w, got)
  endtask : read_word

  task automatic t_reset();
    `CHK("busy_rst", 1'b0, busy)
    `CHK("ref_rst", 1'b1, refp)
    `CHK("ready_rst", 1'b0, rdy)
    `CHK("oe_rst", 1'b0, oe)
  endtask : t_reset

  // Before the hold-off ends the result is flagged invalid
  task automatic t_early();
    conv(1'b0, 18'h2A5C3);
    `CHK("result_early", 1'b0, rok)
    `CHK("oe_on", 1'b1, oe)
    read_word(18'h2A5C3, 1'b0);
    `CHK("ready_por", 1'b1, rdy)
  endtask : t_early

  task automatic t_acq();
    conv(1'b0, 18'h15A3C);
    `CHK("result_ok", 1'b1, rok)
    read_word(18'h15A3C, 1'b1);
    conv(1'b0, 18'h00001);
    read_word(18'h00001, 1'b0);
  endtask : t_acq

  task automatic t_sleep();
    int n = 0;
    logic b;
    conv(1'b1, 18'h3FFFF);
    `CHK("ref_sleep", 1'b0, refp)
    `CHK("ready_sleep", 1'b0, rdy)
    refused();
    fork
      host.sck_bit(b);
    join_none
    for (int t = 0; t < 60 && refp !== 1'b1; t++) begin
      @(posedge clk_i);
      #1;
      n++;
    end
    `CHK("wake_delay", 1'b1, n >= 20 && n <= 26)
    repeat (20) @(posedge clk_i);
    conv(1'b0, 18'h20000);
    `CHK("ready_awake", 1'b1, rdy)
    read_word(18'h20000, 1'b0);
  endtask : t_sleep

  // Each result passes the FIFO in turn; a clock rise parts the starts
  task automatic t_fifo();
    logic b;
    conv(1'b0, 18'h1FFFF);
    host.sck_bit(b);
    `CHK("fifo_bit16", 1'b1, b)
    repeat (sac_pkg::ACQ_CYC) @(posedge clk_i);
    conv(1'b0, 18'h2AAAB);
    `CHK("fifo_ok", 1'b1, rok)
    read_word(18'h2AAAB, 1'b0);
    host.sck_bit(b);
    `CHK("fifo_tail", 1'b0, b)
  endtask : t_fifo

  initial begin
    repeat (4) @(posedge clk_i);
    t_reset();
    rstn_i <= 1'b1;
    t_early();
    t_acq();
    t_sleep();
    t_fifo();
    print_verdict();
  end

  // Whole run is a few thousand cycles
  initial begin
    #100000;
    miscompares++;
    print_verdict();
  end
endmodule : testbench

// [verilog/sac_conv_ctrl.sv]
// Conversion sequencing, nap/sleep power control and result readout
//
// Notes on behaviour
// - Rising convert_start powers the core and starts converting the sample.
// - Start edges during a running conversion never restart it.
// - Busy stays high for the whole conversion, low when it ends.
// - Conversion end powers the core down and returns to acquiring, or enters sleep if requested.
// - Conversion is timed internally, at most 527ns long.
// - At least 460ns acquisition between conversions, giving 1Msps.
// - Nap follows each conversion not ending in sleep; next start edge fully powers up.
// - In nap only the core is off; readout keeps working.
// - Sleep is entered at busy fall of the last conversion started.
// - A serial clock rise wakes the device from sleep.
// - Reset at power-up or supply drop, then re-initialise.
// - Result is an 18-bit two's complement value.
// - Result MSB is on the serial output as busy falls.
// - Serial output changes on each rising serial clock edge, except while busy (ST_CONV and ST_LOAD).
`timescale 1ns/1ps
module sac_conv_ctrl #(
  parameter int POR_CYC = sac_pkg::POR_CYC,
  parameter int WAKE_CYC = sac_pkg::WAKE_CYC,
  parameter int DEPTH = sac_pkg::FIFO_DEPTH
) (
  // Clock and power-on reset
  input wire logic clk_i,
  input wire logic rstn_i,
  // Pins from the host
  input wire logic convert_start_i,
  input wire logic sck_i,
  input wire logic sdo_en_i,
  // Sampled value from the converter core
  input wire logic [sac_pkg::RES_W-1:0] sample_i,
  // Pins to the host
  output logic busy_o,
  output logic sdo_o,
  output logic sdo_oe_o,
  // Power and status
  output logic core_pwr_o,
  output logic ref_pwr_o,
  output logic ready_o,
  output logic result_ok_o
);
  localparam int RW = sac_pkg::RES_W;
  localparam int TW = sac_pkg::TMR_W;
  localparam int PW = sac_pkg::POR_W;
  localparam int A_CONV = sac_pkg::CONV_CYC + 1;

  sac_pkg::sac_state_e state, next_state;
  logic [sac_pkg::PIN_N-1:0] pin_meta, pin_sync, pin_last;
  logic [TW-1:0] tmr, next_tmr;
  logic [PW-1:0] por_cnt, next_por_cnt;
  logic por_done, next_por_done;
  logic armed, next_armed, sleep_req, next_sleep_req;
  logic [RW-1:0] shift, next_shift;
  logic loaded, next_loaded, next_result_ok;
  logic start_ok, next_start_ok;
  logic next_busy, next_core_pwr, next_ref_pwr, next_ready;
  logic cnv_rise, sck_rise, live;
  logic in_valid, in_ready, out_valid, out_ready;
  logic [RW:0] out_data;

  // Pins come from the host's domain; only pin_sync and pin_last feed logic
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      pin_meta <= '0;
      pin_sync <= '0;
      pin_last <= '0;
    end else begin
      pin_meta <= {sdo_en_i, sck_i, convert_start_i};
      pin_sync <= pin_meta;
      pin_last <= pin_sync;
    end
  end

  assign cnv_rise = pin_sync[sac_pkg::PIN_CNV] & ~pin_last[sac_pkg::PIN_CNV];
  assign sck_rise = pin_sync[sac_pkg::PIN_SCK] & ~pin_last[sac_pkg::PIN_SCK];
  // Start edges count only while awake
  assign live = (state != sac_pkg::ST_SLEEP) && (state != sac_pkg::ST_WAKE);
  assign in_valid = (state == sac_pkg::ST_CONV) && (tmr == '0);
  assign out_ready = (state == sac_pkg::ST_LOAD);

  sac_fifo #(
    .WIDTH(RW + 1),
    .DEPTH(DEPTH)
  ) u_fifo (
    .clk_i(clk_i),
    .rstn_i(rstn_i),
    .in_valid_i(in_valid),
    .in_ready_o(in_ready),
    .in_data_i({start_ok, sample_i}),
    .out_valid_o(out_valid),
    .out_ready_i(out_ready),
    .out_data_o(out_data)
  );

  always_comb begin
    next_state = state;
    next_tmr = (tmr != '0) ? tmr - 1'b1 : tmr;
    next_por_cnt = por_cnt;
    next_por_done = por_done;
    next_armed = armed;
    next_sleep_req = sleep_req;
    next_shift = shift;
    next_loaded = loaded;
    next_start_ok = start_ok;
    next_result_ok = result_ok_o;
    // Hold-off after reset before results are trusted
    if (!por_done) begin
      next_por_cnt = por_cnt + 1'b1;
      next_por_done = (por_cnt == PW'(POR_CYC - 1));
    end
    // A clock rise breaks a pending pulse pair; a start edge re-arms
    if (sck_rise) begin
      next_armed = 1'b0;
    end
    if (cnv_rise && live) begin
      next_armed = 1'b1;
      if (armed) begin
        next_sleep_req = 1'b1;
      end
    end
    // Readout runs in every state but ST_CONV and ST_LOAD (loaded clear), so nap does not block it
    if (sck_rise && loaded) begin
      next_shift = {shift[RW-2:0], 1'b0};
    end
    unique case (state)
      sac_pkg::ST_ACQ: begin
        if (cnv_rise && tmr == '0) begin
          next_state = sac_pkg::ST_CONV;
          next_tmr = TW'(sac_pkg::CONV_CYC - 1);
          next_loaded = 1'b0;
          // Validity is fixed at the start edge, not at the end
          next_start_ok = por_done;
        end
      end
      sac_pkg::ST_CONV: begin
        // Extra start edges only arm sleep, never reload the timer
        if (in_valid && in_ready) begin
          next_state = sac_pkg::ST_LOAD;
        end
      end
      sac_pkg::ST_LOAD: begin
        if (out_valid) begin
          next_shift = out_data[RW-1:0];
          next_result_ok = out_data[RW];
          next_loaded = 1'b1;
          next_tmr = TW'(sac_pkg::ACQ_CYC - 1);
          next_state = sac_pkg::ST_ACQ;
          if (sleep_req || (cnv_rise && armed)) begin
            next_state = sac_pkg::ST_SLEEP;
            next_sleep_req = 1'b0;
            next_armed = 1'b0;
          end
        end
      end
      sac_pkg::ST_SLEEP: begin
        if (sck_rise) begin
          next_state = sac_pkg::ST_WAKE;
          next_tmr = TW'(WAKE_CYC - 1);
        end
      end
      sac_pkg::ST_WAKE: begin
        if (tmr == '0) begin
          next_state = sac_pkg::ST_ACQ;
        end
      end
      default: begin
        next_state = sac_pkg::ST_ACQ;
      end
    endcase
    next_busy = (next_state == sac_pkg::ST_CONV) ||
                (next_state == sac_pkg::ST_LOAD);
    next_core_pwr = (next_state == sac_pkg::ST_CONV);
    next_ref_pwr = (next_state != sac_pkg::ST_SLEEP) &&
                   (next_state != sac_pkg::ST_WAKE);
    next_ready = next_por_done && next_ref_pwr;
  end

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      state <= sac_pkg::ST_ACQ;
      tmr <= '0;
      por_cnt <= '0;
      por_done <= 1'b0;
      armed <= 1'b0;
      sleep_req <= 1'b0;
      shift <= '0;
      loaded <= 1'b0;
      start_ok <= 1'b0;
      result_ok_o <= 1'b0;
      busy_o <= 1'b0;
      core_pwr_o <= 1'b0;
      ref_pwr_o <= 1'b1;
      ready_o <= 1'b0;
      sdo_oe_o <= 1'b0;
    end else begin
      state <= next_state;
      tmr <= next_tmr;
      por_cnt <= next_por_cnt;
      por_done <= next_por_done;
      armed <= next_armed;
      sleep_req <= next_sleep_req;
      shift <= next_shift;
      loaded <= next_loaded;
      start_ok <= next_start_ok;
      result_ok_o <= next_result_ok;
      busy_o <= next_busy;
      core_pwr_o <= next_core_pwr;
      ref_pwr_o <= next_ref_pwr;
      ready_o <= next_ready;
      sdo_oe_o <= pin_sync[sac_pkg::PIN_SDOEN];
    end
  end

  assign sdo_o = shift[RW-1];

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rstn_i);

  chk_start_busy: assert property (
    (state == sac_pkg::ST_ACQ && cnv_rise && tmr == '0)
      |=> busy_o && core_pwr_o
  ) else $error("start edge did not raise busy and core power");
  chk_no_restart: assert property (
    (state == sac_pkg::ST_CONV && tmr != '0)
      |=> state == sac_pkg::ST_CONV && tmr == $past(tmr) - 1'b1
  ) else $error("running conversion was disturbed");
  chk_busy_match: assert property (
    busy_o == (state == sac_pkg::ST_CONV || state == sac_pkg::ST_LOAD)
  ) else $error("busy does not match conversion state");
  chk_core_off: assert property (
    $fell(busy_o) |-> !core_pwr_o && state != sac_pkg::ST_CONV
  ) else $error("core still powered after conversion");
  chk_conv_time: assert property (
    $rose(core_pwr_o) |-> ##[1:A_CONV] !core_pwr_o
  ) else $error("conversion ran too long");
  chk_acq_gap: assert property (
    (state == sac_pkg::ST_ACQ && tmr != '0) |=> state != sac_pkg::ST_CONV
  ) else $error("conversion started inside acquisition time");
  chk_sleep_enter: assert property (
    ($fell(busy_o) && $past(sleep_req))
      |-> state == sac_pkg::ST_SLEEP && !ref_pwr_o
  ) else $error("sleep not entered at busy fall");
  chk_wake_edge: assert property (
    (state == sac_pkg::ST_SLEEP && sck_rise) |=> state == sac_pkg::ST_WAKE
  ) else $error("clock rise did not wake the device");
  chk_msb_fall: assert property (
    $fell(busy_o) |-> sdo_o == $past(out_data[RW-1]) && loaded
  ) else $error("result msb not presented at busy fall");
  chk_shift_rise: assert property (
    (sck_rise && loaded && state != sac_pkg::ST_LOAD)
      |=> shift == {$past(shift[RW-2:0]), 1'b0}
  ) else $error("serial data did not advance on clock rise");
  chk_por_block: assert property (
    !por_done |-> !ready_o
  ) else $error("ready shown before reset hold-off ended");

  cov_conversion: cover property ($rose(busy_o) ##[1:A_CONV] $fell(busy_o));
  cov_sleep: cover property ($rose(state == sac_pkg::ST_SLEEP));
  cov_wake: cover property (
    state == sac_pkg::ST_WAKE ##1 state == sac_pkg::ST_ACQ);
endmodule : sac_conv_ctrl

// [verilog/sac_fifo.sv]
// Small result FIFO with valid/ready on both sides
`timescale 1ns/1ps
module sac_fifo #(
  parameter int WIDTH = 19,
  parameter int DEPTH = 4
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rstn_i,
  // Fill side
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [WIDTH-1:0] in_data_i,
  // Drain side
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [WIDTH-1:0] out_data_o
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam logic [AW-1:0] LAST = AW'(DEPTH - 1);
  localparam logic [AW:0] FULL = (AW + 1)'(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr, rd_ptr, next_wr_ptr, next_rd_ptr;
  logic [AW:0] count, next_count;
  logic push, pop;

  assign in_ready_o = (count != FULL);
  assign out_valid_o = (count != '0);
  assign out_data_o = mem[rd_ptr];
  assign push = in_valid_i && in_ready_o;
  assign pop = out_valid_o && out_ready_i;

  always_comb begin
    next_wr_ptr = wr_ptr;
    next_rd_ptr = rd_ptr;
    next_count = count;
    if (push) begin
      next_wr_ptr = (wr_ptr == LAST) ? '0 : wr_ptr + 1'b1;
    end
    if (pop) begin
      next_rd_ptr = (rd_ptr == LAST) ? '0 : rd_ptr + 1'b1;
    end
    if (push && !pop) begin
      next_count = count + 1'b1;
    end else if (pop && !push) begin
      next_count = count - 1'b1;
    end
  end

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
    end else begin
      wr_ptr <= next_wr_ptr;
      rd_ptr <= next_rd_ptr;
      count <= next_count;
    end
  end

  // Storage has no reset; a word is read only after it was written
  always_ff @(posedge clk_i) begin
    if (push) begin
      mem[wr_ptr] <= in_data_i;
    end
  end
endmodule : sac_fifo

// [verilog/sac_pkg.sv]
// Constants and types shared by the conversion controller and the testbench
package sac_pkg;
  localparam int RES_W = 18;
  localparam int CLK_MHZ = 250;
  localparam int CONV_MAX_NS = 527;
  localparam int CONV_CYC = (CONV_MAX_NS * CLK_MHZ) / 1000;
  localparam int ACQ_MIN_NS = 460;
  localparam int ACQ_CYC = (ACQ_MIN_NS * CLK_MHZ + 999) / 1000;
  localparam int CNV_GUARD_NS = 40;
  localparam int POR_MS = 100;
  localparam int POR_CYC = POR_MS * CLK_MHZ * 1000;
  localparam int WAKE_NS = 1000;
  localparam int WAKE_CYC = (WAKE_NS * CLK_MHZ + 999) / 1000;
  localparam int FIFO_DEPTH = 4;
  localparam int TMR_W = 20;
  localparam int POR_W = 25;
  localparam int PIN_CNV = 0;
  localparam int PIN_SCK = 1;
  localparam int PIN_SDOEN = 2;
  localparam int PIN_N = 3;
  typedef enum logic [2:0] {
    ST_ACQ = 3'h0,
    ST_CONV = 3'h1,
    ST_LOAD = 3'h2,
    ST_SLEEP = 3'h3,
    ST_WAKE = 3'h4
  } sac_state_e;
endpackage : sac_pkg
